// File: src/ddpf_ctrl.sv
// power, reference and fault control of a dual voltage-output dac
// assumes requests come from a frame decoder on clk and fault inputs are asynchronous
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R01 - A access with register select 010 targets the power control register.
// R02 - Channel A runs when its power-up bit is set and is powered down when clear, clear at reset.
// R03 - Channel B runs when its power-up bit is set and is powered down when clear, clear at reset.
// R04 - The host waits 10 us after setting a power-up bit before loading that channel's output.
// R05 - With clamp disabled an overcurrent powers the channel down and clears its power-up bit.
// R06 - The reference power-up bit enables the internal reference, which resets powered down.
// R07 - The read-only thermal bit is set on overtemperature and both channels power down.
// R08 - The read-only channel A overcurrent bit is set while channel A is overcurrent.
// R09 - The read-only channel B overcurrent bit is set while channel B is overcurrent.
// R10 - With clamp enabled a shorted channel stays up at 20 mA and its flag follows the fault.
// R11 - At supply power-up outputs sit at 0 V, amplifiers off, until supplies settle and data arrives.
// R12 - Each channel powers down alone, grounding its pin through 4k and disconnecting its amplifier.
// R13 - After an automatic power-down the host must set the power-up bits again.
// R14 - Thermal shutdown is off after reset and acts only once its enable bit is set.
// R15 - With an external reference the host keeps the reference power-up bit clear.
// R16 - Clamp enable resets set, selecting the current clamp; clear selects auto power-down.
// R17 - Power register readback returns live power-up bits, reference bit and alert flags.
module ddpf_ctrl
   import ddpf_pkg::*;
(
   input wire logic clk,                 // 100 MHz clock
   input wire logic nrst,                // async reset, active low
   input wire ddpf_req_t req,            // parsed register access
   input wire ddpf_fault_t fault_raw,    // asynchronous analog comparators
   output ddpf_ana_t ana,                // analog switch controls
   output logic rd_valid,                // readback word strobe
   output logic [15:0] rd_data           // readback word
);

   ////////////////////////////////////////////////////////////////////////////
   // synchronise the asynchronous fault comparators
   ddpf_fault_t sync1_q;
   ddpf_fault_t sync2_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= fault_raw;
         sync2_q <= sync1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] pack_power(input ddpf_state_t s);
      logic [15:0] w;
      w = '0;
      w[DDPF_PU_A_BIT] = s.pu_a;
      w[DDPF_PU_B_BIT] = s.pu_b;
      w[DDPF_VREF_POWER_ON_BIT] = s.vref_power_on;
      w[DDPF_TSD_BIT] = s.overtemp_alert;
      w[DDPF_OC_A_BIT] = s.oc_a;
      w[DDPF_OC_B_BIT] = s.oc_b;
      return w;
   endfunction : pack_power

   function automatic logic [15:0] pack_control(input ddpf_state_t s);
      logic [15:0] w;
      w = '0;
      w[DDPF_CLAMP_BIT] = s.clamp_en;
      w[DDPF_TSD_EN_BIT] = s.tsd_en;
      return w;
   endfunction : pack_control

   ////////////////////////////////////////////////////////////////////////////
   ddpf_state_t st_q;
   ddpf_state_t st_d;
   logic wr_pwr;
   logic wr_ctl;
   logic thermal_trip;

   always_comb begin
      st_d = st_q;
      st_d.rd_valid = 1'b0;
      wr_pwr = req.valid && !req.rd && (req.reg_sel == DDPF_REG_POWER); // see R01
      wr_ctl = req.valid && !req.rd && (req.reg_sel == DDPF_REG_CONTROL)
               && (req.addr == DDPF_CTRL_FUNC);
      thermal_trip = st_q.tsd_en && sync2_q.overtemp; // see R14

      // host writes; only the power-up bits and the control enable bits are writable, alert bits read-only
      if (wr_pwr) begin
         st_d.pu_a = req.data[DDPF_PU_A_BIT];     // see R02
         st_d.pu_b = req.data[DDPF_PU_B_BIT];     // see R03
         st_d.vref_power_on = req.data[DDPF_VREF_POWER_ON_BIT]; // see R06
      end
      if (wr_ctl) begin
         st_d.clamp_en = req.data[DDPF_CLAMP_BIT];  // see R16
         st_d.tsd_en = req.data[DDPF_TSD_EN_BIT];   // see R14
      end
      // a dac data register write while supplies_ok is set counts as the first valid word
      if (req.valid && !req.rd && req.reg_sel == 3'h0 && sync2_q.supplies_ok) begin
         st_d.valid_word = 1'b1; // see R11
      end
      if (!sync2_q.supplies_ok) begin
         st_d.valid_word = 1'b0; // see R11
      end

      // live alert flags follow the condition
      st_d.oc_a = sync2_q.oc_a; // see R08, R10
      st_d.oc_b = sync2_q.oc_b; // see R09, R10
      // thermal flag latches until the enable is cleared by software
      if (thermal_trip) begin
         st_d.overtemp_alert = 1'b1; // see R07
      end else if (wr_ctl && !req.data[DDPF_TSD_EN_BIT]) begin
         st_d.overtemp_alert = 1'b0;
      end

      // fault power-downs win over a same-cycle host write of the power-up bit
      if (!st_q.clamp_en && sync2_q.oc_a) begin
         st_d.pu_a = 1'b0; // see R05
      end
      if (!st_q.clamp_en && sync2_q.oc_b) begin
         st_d.pu_b = 1'b0; // see R05
      end
      if (thermal_trip) begin
         st_d.pu_a = 1'b0; // see R07
         st_d.pu_b = 1'b0; // see R07
      end

      // output switches: amplifier and ground clamp are always complementary
      st_d.ana.amp_on_a = st_d.pu_a && st_d.valid_word;  // see R02, R11, R12
      st_d.ana.amp_on_b = st_d.pu_b && st_d.valid_word;  // see R03, R11, R12
      st_d.ana.clamp_gnd_a = !st_d.ana.amp_on_a;         // see R12
      st_d.ana.clamp_gnd_b = !st_d.ana.amp_on_b;         // see R12
      st_d.ana.ilimit_a = st_q.clamp_en && sync2_q.oc_a && st_d.pu_a; // see R10
      st_d.ana.ilimit_b = st_q.clamp_en && sync2_q.oc_b && st_d.pu_b; // see R10
      st_d.ana.vref_on = st_d.vref_power_on;                    // see R06

      // readback of the current state, not the written value
      if (req.valid && req.rd) begin
         st_d.rd_valid = 1'b1;
         if (req.reg_sel == DDPF_REG_POWER) begin
            st_d.rd_data = pack_power(st_q); // see R17, R01
         end else if (req.reg_sel == DDPF_REG_CONTROL) begin
            st_d.rd_data = pack_control(st_q);
         end else begin
            st_d.rd_data = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= '0;
         st_q.pu_a <= DDPF_PU_RST;
         st_q.pu_b <= DDPF_PU_RST;
         st_q.vref_power_on <= DDPF_PU_RST;
         st_q.clamp_en <= DDPF_CLAMP_RST;
         st_q.tsd_en <= DDPF_TSD_EN_RST;
         st_q.ana.clamp_gnd_a <= 1'b1;
         st_q.ana.clamp_gnd_b <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign ana = st_q.ana;
   assign rd_valid = st_q.rd_valid;
   assign rd_data = st_q.rd_data;
endmodule : ddpf_ctrl

// File: src/ddpf_pkg.sv
// package for the dual dac power and fault control block
// assumes a frame decoder upstream that delivers parsed 24-bit register accesses
package ddpf_pkg;
   // register select code of the power control register
   localparam logic [2:0] DDPF_REG_POWER = 3'h2;
   // register select code of the control register (clamp and thermal enables)
   localparam logic [2:0] DDPF_REG_CONTROL = 3'h3;
   // control register function address for the enable bits
   localparam logic [2:0] DDPF_CTRL_FUNC = 3'h1;
   // power register field positions
   localparam int DDPF_PU_A_BIT = 0;
   localparam int DDPF_PU_B_BIT = 2;
   localparam int DDPF_VREF_POWER_ON_BIT = 4;
   localparam int DDPF_TSD_BIT = 5;
   localparam int DDPF_OC_A_BIT = 7;
   localparam int DDPF_OC_B_BIT = 9;
   // control register field positions
   localparam int DDPF_CLAMP_BIT = 2;
   localparam int DDPF_TSD_EN_BIT = 3;
   // reset values
   localparam logic DDPF_PU_RST = 1'b0;
   localparam logic DDPF_CLAMP_RST = 1'b1;
   localparam logic DDPF_TSD_EN_RST = 1'b0;
   // power-up time the host must wait, and its cycle count at 100 MHz
   localparam int DDPF_PWRUP_NS = 10000;
   localparam int DDPF_CLK_NS = 10;
   localparam int DDPF_PWRUP_CYC = (DDPF_PWRUP_NS + DDPF_CLK_NS - 1) / DDPF_CLK_NS;

   // one parsed register access from the serial frame decoder
   typedef struct packed {
      logic valid;        // one-cycle strobe
      logic rd;           // 1 = readback request
      logic [2:0] reg_sel;
      logic [2:0] addr;
      logic [15:0] data;
   } ddpf_req_t;

   // raw analog fault comparators
   typedef struct packed {
      logic oc_a;
      logic oc_b;
      logic overtemp;
      logic supplies_ok;
   } ddpf_fault_t;

   // output switch controls per channel
   typedef struct packed {
      logic amp_on_a;     // amplifier enabled and connected
      logic amp_on_b;
      logic clamp_gnd_a;  // 4k pull to ground engaged
      logic clamp_gnd_b;
      logic ilimit_a;     // 20 mA limiter active
      logic ilimit_b;
      logic vref_on;
   } ddpf_ana_t;

   typedef struct packed {
      logic pu_a;
      logic pu_b;
      logic vref_power_on;
      logic overtemp_alert;
      logic oc_a;
      logic oc_b;
      logic clamp_en;
      logic tsd_en;
      logic valid_word;   // a dac data word seen since supply power-up
      ddpf_ana_t ana;
      logic rd_valid;
      logic [15:0] rd_data;
   } ddpf_state_t;
endpackage : ddpf_pkg

// File: verif/ddpf_host.sv
// host model issuing parsed register accesses
// assumes a request is taken on the edge that sees valid
`timescale 1ns/1ps
module ddpf_host
   import ddpf_pkg::*;
(
   input wire logic clk, // clock
   output ddpf_req_t req // access toward the block
);
   initial req = '0;
   task automatic xfer(input logic rd, input logic [2:0] sel, input logic [2:0] adr,
      input logic [15:0] dat);
      @(posedge clk);
      req <= {1'b1, rd, sel, adr, dat};
      @(posedge clk);
      req <= {1'b0, ~rd, ~sel, ~adr, ~dat}; // idle fields toggle, never look stale
   endtask : xfer
   // the data word waits out settling so no output loads mid power-up
   task automatic power(input logic [15:0] bits);
      xfer(1'b0, DDPF_REG_POWER, 3'h0, bits);
      repeat (DDPF_PWRUP_CYC) @(posedge clk);
      xfer(1'b0, 3'h0, 3'h4, 16'h8000);
   endtask : power
endmodule : ddpf_host

// File: verif/ddpf_sva.sv
// assertions on the power and fault control ports
// assumes the enables change only by control writes
`timescale 1ns/1ps
module ddpf_sva
   import ddpf_pkg::*;
(
   input wire logic clk, // clock
   input wire logic nrst, // reset
   input wire ddpf_req_t req, // access
   input wire ddpf_fault_t fault_raw, // faults
   input wire ddpf_ana_t ana, // switches
   input wire logic rd_valid // read strobe
);
   logic clamp_q, tsd_q;
   wire wr_pwr = req.valid && !req.rd && req.reg_sel == DDPF_REG_POWER;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) {tsd_q, clamp_q} <= {DDPF_TSD_EN_RST, DDPF_CLAMP_RST};
      else if (req.valid && !req.rd && req.reg_sel == DDPF_REG_CONTROL
         && req.addr == DDPF_CTRL_FUNC) {tsd_q, clamp_q} <= req.data[3:2];
   end
   ////////////////////////////////////////////////////////////////
   // four samples cover the two-flop sync plus the state update
   sequence s_auto_b; (!clamp_q && fault_raw.oc_b) [*4]; endsequence
   sequence s_clamp_a; (clamp_q && fault_raw.oc_a && ana.amp_on_a) [*4]; endsequence
   sequence s_hot; (tsd_q && fault_raw.overtemp) [*4]; endsequence
   a_read_strobe: assert property (req.valid && req.rd |=> rd_valid)
      else $error("no read strobe");
   a_read_quiet: assert property (!(req.valid && req.rd) |=> !rd_valid)
      else $error("stray read strobe");
   a_pin_clamp: assert property (
      ana.clamp_gnd_a != ana.amp_on_a && ana.clamp_gnd_b != ana.amp_on_b)
      else $error("clamp and amp overlap");
   a_ref_on: assert property (wr_pwr && req.data[4] |-> ##[1:2] ana.vref_on)
      else $error("reference stays off");
   a_supply_off: assert property (
      !fault_raw.supplies_ok [*4] |-> !ana.amp_on_a && !ana.amp_on_b)
      else $error("amp on without supply");
   a_auto_down: assert property (s_auto_b |-> !ana.amp_on_b)
      else $error("no auto power-down");
   a_clamp_limit: assert property (s_clamp_a |-> ana.ilimit_a)
      else $error("no current limit");
   a_thermal_down: assert property (
      s_hot |-> !ana.amp_on_a && !ana.amp_on_b)
      else $error("no thermal shutdown");
endmodule : ddpf_sva
bind ddpf_ctrl ddpf_sva u_sva (.clk(clk), .nrst(nrst), .req(req), .fault_raw(fault_raw),
   .ana(ana), .rd_valid(rd_valid));

// File: verif/dual_dac_power_fault_control_tb.sv
// bench for the power and fault control block
// assumes the host model makes every access
`timescale 1ns/1ps
module dual_dac_power_fault_control_tb;
   import ddpf_pkg::*;
   logic clk, nrst, rd_valid;
   ddpf_req_t req;
   ddpf_fault_t fault_raw;
   ddpf_ana_t ana;
   logic [15:0] rd_data, r;
   int bad_count = 0, comparisons = 0, cycles = 0, seed = 32'h306e535f;
   ddpf_host host (.clk(clk), .req(req));
   ddpf_ctrl dut (.clk(clk), .nrst(nrst), .req(req), .fault_raw(fault_raw), .ana(ana),
      .rd_valid(rd_valid), .rd_data(rd_data));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // f is {oc_b, oc_a, tsd, ref, b, a}; x is {amp a, amp b, limit a, limit b, ref}
   task automatic rd_pwr(input logic [5:0] f, input logic [4:0] x);
      logic [15:0] w;
      w = '0;
      {w[9], w[7], w[5], w[4], w[2], w[0]} = f;
      host.xfer(1'b1, DDPF_REG_POWER, 3'h0, 16'h0);
      #1;
      check("read strobe", 16'h0001, {15'h0, rd_valid});
      check("power word", w, rd_data);
      check("ana", {9'h0, x[4:3], ~x[4:3], x[2:0]}, {9'h0, ana});
   endtask : rd_pwr
   task automatic wr(input logic [2:0] sel, input logic [15:0] d);
      host.xfer(1'b0, sel, (sel == DDPF_REG_CONTROL) ? DDPF_CTRL_FUNC : 3'h0, d);
   endtask : wr
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      nrst = 0;
      fault_raw = 4'h1;
      repeat (8) @(posedge clk);
      nrst <= 1;
      rd_pwr(6'h00, 5'h00);
      host.xfer(1'b1, DDPF_REG_CONTROL, DDPF_CTRL_FUNC, 16'h0);
      #1 check("control", 16'h0004, rd_data);
      host.xfer(1'b1, 3'h5, 3'h0, 16'h0);
      #1 check("unmapped", 16'h0000, rd_data);
      wr(DDPF_REG_POWER, 16'hffff);
      rd_pwr(6'h07, 5'h01);
      host.power(16'h0015);
      rd_pwr(6'h07, 5'h19);
      repeat (8) begin
         r = 16'($random(seed));
         wr(DDPF_REG_POWER, r);
         rd_pwr({3'h0, r[4], r[2], r[0]}, {r[0], r[2], 2'h0, r[4]});
      end
      // an external reference is assumed from here on, so the reference bit stays clear
      wr(DDPF_REG_POWER, 16'h0005);
      fault_raw.oc_a <= 1;
      repeat (4) @(posedge clk);
      rd_pwr(6'h13, 5'h1c);
      fault_raw.oc_a <= 0;
      repeat (4) @(posedge clk);
      rd_pwr(6'h03, 5'h18);
      wr(DDPF_REG_CONTROL, 16'h0);
      fault_raw.oc_b <= 1;
      repeat (4) @(posedge clk);
      rd_pwr(6'h21, 5'h10);
      fault_raw.oc_b <= 0;
      repeat (4) @(posedge clk);
      wr(DDPF_REG_POWER, 16'h0005);
      rd_pwr(6'h03, 5'h18);
      fault_raw.overtemp <= 1;
      repeat (4) @(posedge clk);
      rd_pwr(6'h03, 5'h18);
      wr(DDPF_REG_CONTROL, 16'h0008);
      repeat (4) @(posedge clk);
      rd_pwr(6'h08, 5'h00);
      fault_raw.supplies_ok <= 0;
      repeat (4) @(posedge clk);
      rd_pwr(6'h08, 5'h00);
      conclude();
   end
endmodule : dual_dac_power_fault_control_tb
